//--- src/acd_pkg.sv
package acd_pkg;

	// ************************************************************
	// Register map, byte addresses on the bus.
	// ************************************************************
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_PRECHG = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;
	localparam logic [7:0] ADR_ACTIVE = 8'h0c;
	localparam logic [7:0] ADR_SOFTRST = 8'h10;

	// ************************************************************
	// Field positions.
	// ************************************************************
	localparam int CTRL_FILT_BIT = 0;
	localparam int CTRL_DEC_LSB = 1;
	localparam int CTRL_PWR_LSB = 3;
	localparam int CTRL_DATA_CLOCK_LSB = 5;
	localparam int CTRL_ONESHOT_BIT = 7;
	localparam int CTRL_MDIV_LSB = 8;
	localparam int PRE_AIN_LSB = 0;
	localparam int PRE_REF_LSB = 8;
	localparam int STAT_SERIAL_BIT = 0;
	localparam int STAT_VALID_BIT = 1;
	localparam int STAT_FMT_LSB = 2;
	localparam int STAT_STATE_LSB = 4;

	// ************************************************************
	// Reset values, key and timing counts.
	// ************************************************************
	localparam logic [31:0] CTRL_RST = 32'h0000_0200;
	localparam logic [31:0] PRECHG_RST = 32'h0000_00ff;
	localparam logic [7:0] SOFTRST_KEY = 8'ha5;
	localparam logic [1:0] CAP_CYCLES = 2'h3;
	localparam int NUM_CH = 8;

	// ************************************************************
	// Encodings.
	// ************************************************************
	typedef enum logic [1:0] {
		PWR_FOCUS = 2'h0,
		PWR_MEDIAN = 2'h1,
		PWR_FAST = 2'h2
	} acd_pwr_e;

	typedef enum logic [1:0] {
		MDIV_4 = 2'h0,
		MDIV_8 = 2'h1,
		MDIV_32 = 2'h2
	} acd_mdiv_e;

	typedef enum logic [1:0] {
		DATA_CLOCK_DIV1 = 2'h0,
		DATA_CLOCK_DIV2 = 2'h1,
		DATA_CLOCK_DIV4 = 2'h2,
		DATA_CLOCK_DIV8 = 2'h3
	} acd_data_clock_e;

	typedef enum logic [1:0] {
		DEC_32 = 2'h0,
		DEC_64 = 2'h1,
		DEC_128 = 2'h2,
		DEC_1024 = 2'h3
	} acd_dec_e;

	typedef enum logic [1:0] {
		ST_CAPT = 2'b01,
		ST_RUN = 2'b10
	} acd_state_e;

	typedef struct packed {
		logic sinc5;
		acd_dec_e decim;
		acd_pwr_e pwr;
		acd_data_clock_e data_clock;
		logic one_shot;
		acd_mdiv_e mdiv;
		logic [NUM_CH-1:0] ain_buf;
		logic [NUM_CH-1:0] ref_buf;
	} acd_cfg_s;

	typedef struct packed {
		logic ctrl_serial;
		logic filter_sinc5;
		logic decim_select_hi;
		logic decim_select_lo;
		logic [3:0] mode_strap_pins;
		logic [1:0] output_format_select;
		logic start_n;
		logic sync_in_n;
		logic supply_fault;
	} acd_pins_s;

endpackage : acd_pkg

//--- src/acd_strap_decoder.sv
// Our own choices: register access over Wishbone and the placing of the registers.
module acd_strap_decoder (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Strap and sync pins.
	input wire acd_pkg::acd_pins_s strap_pins_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Applied configuration.
	output acd_pkg::acd_cfg_s cfg_o,
	output logic cfg_valid_o,
	output logic serial_mode_o,
	output logic [1:0] output_format_select_o,
	output logic shared_data_out_o
);
	import acd_pkg::*;

	// ************************************************************
	// Pin synchronisers.
	// ************************************************************
	acd_pins_s pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_ff, pin_prev_ff;

	always_ff @(posedge clk_i) begin
		pin_s1_ff <= strap_pins_i;
		pin_s2_ff <= pin_s1_ff;
		pin_s3_ff <= pin_s2_ff;
	end

	// A bit changes only once the second and third stages agree.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_ff <= '0;
			pin_prev_ff <= '0;
		end else begin
			pin_ff <= (pin_s2_ff & pin_s3_ff) |
				(pin_ff & (pin_s2_ff ^ pin_s3_ff));
			pin_prev_ff <= pin_ff;
		end
	end

	logic sync_evt;
	logic fault_evt;
	assign sync_evt = (pin_prev_ff.start_n & ~pin_ff.start_n) |
		(pin_prev_ff.sync_in_n & ~pin_ff.sync_in_n);
	assign fault_evt = pin_ff.supply_fault & ~pin_prev_ff.supply_fault;

	// ************************************************************
	// Decoders.
	// ************************************************************
	function automatic acd_mdiv_e mod_div(input acd_pwr_e p);
		case (p)
			PWR_FAST: mod_div = MDIV_4;
			PWR_MEDIAN: mod_div = MDIV_8;
			default: mod_div = MDIV_32;
		endcase
	endfunction : mod_div

	function automatic acd_cfg_s decode_pins(input acd_pins_s p);
		acd_cfg_s c;
		c = '0;
		c.sinc5 = p.filter_sinc5;
		c.decim = acd_dec_e'({p.decim_select_hi,
			p.decim_select_lo});
		c.ain_buf = '1;
		c.ref_buf = '0;
		case (p.mode_strap_pins)
			4'hc: begin
				c.pwr = PWR_FOCUS;
				c.data_clock = DATA_CLOCK_DIV1;
				c.one_shot = 1'b1;
			end
			4'hd: begin
				c.pwr = PWR_MEDIAN;
				c.data_clock = DATA_CLOCK_DIV1;
				c.one_shot = 1'b1;
			end
			4'he: begin
				c.pwr = PWR_FAST;
				c.data_clock = DATA_CLOCK_DIV2;
				c.one_shot = 1'b1;
			end
			4'hf: begin
				c.pwr = PWR_FAST;
				c.data_clock = DATA_CLOCK_DIV1;
				c.one_shot = 1'b1;
			end
			default: begin
				c.pwr = acd_pwr_e'(p.mode_strap_pins[3:2]);
				c.data_clock = acd_data_clock_e'(p.mode_strap_pins[1:0]);
				c.one_shot = 1'b0;
			end
		endcase
		c.mdiv = mod_div(c.pwr);
		return c;
	endfunction : decode_pins

	function automatic acd_cfg_s decode_regs(input logic [31:0] ctl,
		input logic [31:0] pre);
		acd_cfg_s c;
		c = '0;
		c.sinc5 = ctl[CTRL_FILT_BIT];
		c.decim = acd_dec_e'(ctl[CTRL_DEC_LSB +: 2]);
		c.pwr = acd_pwr_e'(ctl[CTRL_PWR_LSB +: 2]);
		c.data_clock = acd_data_clock_e'(ctl[CTRL_DATA_CLOCK_LSB +: 2]);
		c.one_shot = ctl[CTRL_ONESHOT_BIT];
		c.mdiv = acd_mdiv_e'(ctl[CTRL_MDIV_LSB +: 2]);
		c.ain_buf = pre[PRE_AIN_LSB +: NUM_CH];
		c.ref_buf = pre[PRE_REF_LSB +: NUM_CH];
		return c;
	endfunction : decode_regs

	function automatic logic [31:0] byte_merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[8*i +: 8] = dat[8*i +: 8];
			end
		end
		return r;
	endfunction : byte_merge

	// ************************************************************
	// Bus slave.
	// ************************************************************
	logic [31:0] ctrl_ff, prechg_ff;
	logic ack_ff;
	logic [31:0] dat_ff;
	logic req, wr_req, soft_rst;
	assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr_req = req & wb_we_i;
	assign soft_rst = wr_req & (wb_adr_i == ADR_SOFTRST) & wb_sel_i[0] &
		(wb_dat_i[7:0] == SOFTRST_KEY);

	// Full option set lives here; it steers the block in serial mode.
	always_ff @(posedge clk_i) begin
		if (rst_i || soft_rst) begin
			ctrl_ff <= CTRL_RST;
			prechg_ff <= PRECHG_RST;
		end else if (wr_req && wb_adr_i == ADR_CTRL) begin
			ctrl_ff <= byte_merge(ctrl_ff, wb_dat_i, wb_sel_i) &
				32'h0000_03ff;
		end else if (wr_req && wb_adr_i == ADR_PRECHG) begin
			prechg_ff <= byte_merge(prechg_ff, wb_dat_i, wb_sel_i) &
				32'h0000_ffff;
		end
	end

	// ************************************************************
	// Mode capture and configuration apply.
	// ************************************************************
	acd_state_e state_ff;
	logic [1:0] cap_cnt_ff;
	logic serial_ff;
	logic valid_ff;
	acd_cfg_s cfg_ff;
	acd_cfg_s cand;
	logic cap_done, load_evt;

	// A soft reset in serial mode applies the reset values, not the old ones.
	assign cand = !serial_ff ? decode_pins(pin_ff) :
		soft_rst ? decode_regs(CTRL_RST, PRECHG_RST) :
		decode_regs(ctrl_ff, prechg_ff);
	assign cap_done = (state_ff == ST_CAPT) && (cap_cnt_ff == CAP_CYCLES);
	assign load_evt = (state_ff == ST_RUN) && (sync_evt || soft_rst ||
		(fault_evt && !serial_ff));

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= ST_CAPT;
			cap_cnt_ff <= 2'h0;
		end else begin
			case (state_ff)
				ST_CAPT: begin
					if (cap_done) begin
						state_ff <= ST_RUN;
					end else begin
						cap_cnt_ff <= cap_cnt_ff + 2'h1;
					end
				end
				ST_RUN: state_ff <= ST_RUN;
				default: state_ff <= ST_CAPT;
			endcase
		end
	end

	// The mode is caught once per reset, after the synchroniser settles.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_ff <= 1'b0;
		end else if (cap_done) begin
			serial_ff <= pin_ff.ctrl_serial;
		end
	end

	acd_cfg_s cap_cfg;
	assign cap_cfg = pin_ff.ctrl_serial ? decode_regs(ctrl_ff, prechg_ff) :
		decode_pins(pin_ff);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_ff <= '0;
			valid_ff <= 1'b0;
		end else if (cap_done) begin
			cfg_ff <= cap_cfg;
			valid_ff <= 1'b1;
		end else if (load_evt) begin
			cfg_ff <= cand;
		end
	end

	// Format pins reach the data path whatever the control mode.
	logic [1:0] fmt_ff;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fmt_ff <= 2'h0;
		end else begin
			fmt_ff <= pin_ff.output_format_select;
		end
	end

	// ************************************************************
	// Read mux and answer.
	// ************************************************************
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (wb_adr_i)
			ADR_CTRL: rd_mux = ctrl_ff;
			ADR_PRECHG: rd_mux = prechg_ff;
			ADR_STATUS: begin
				rd_mux[STAT_SERIAL_BIT] = serial_ff;
				rd_mux[STAT_VALID_BIT] = valid_ff;
				rd_mux[STAT_FMT_LSB +: 2] = fmt_ff;
				rd_mux[STAT_STATE_LSB +: 2] = state_ff;
			end
			ADR_ACTIVE: rd_mux[25:0] = cfg_ff;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= req;
			if (req && !wb_we_i) begin
				dat_ff <= rd_mux;
			end
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;
	assign cfg_o = cfg_ff;
	assign cfg_valid_o = valid_ff;
	assign serial_mode_o = serial_ff;
	assign output_format_select_o = fmt_ff;
	assign shared_data_out_o = |fmt_ff;

	// ************************************************************
	// Assertions.
	// ************************************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	acd_cfg_s pin_dec;
	assign pin_dec = decode_pins(pin_ff);

	sequence s_pin_load;
		load_evt && !serial_ff;
	endsequence

	sequence s_quiet;
		!load_evt && !cap_done;
	endsequence

	a_mode_held: assert property ((state_ff == ST_RUN) ##1
		(state_ff == ST_RUN) |-> $stable(serial_ff))
		else $error("control mode changed after capture");
	a_ain_buf_on: assert property (valid_ff && !serial_ff |->
		cfg_ff.ain_buf == '1)
		else $error("input precharge buffer off in pin mode");
	a_ref_buf_off: assert property (valid_ff && !serial_ff |->
		cfg_ff.ref_buf == '0)
		else $error("reference buffer on in pin mode");
	a_cfg_hold: assert property (s_quiet |=> $stable(cfg_ff))
		else $error("configuration changed without sync");
	a_sync_apply: assert property (s_pin_load |=>
		cfg_ff == $past(pin_dec))
		else $error("sync did not apply strap setting");
	a_filter_sel: assert property (s_pin_load |=>
		cfg_ff.sinc5 == $past(pin_ff.filter_sinc5))
		else $error("filter select wrong");
	a_decim_sel: assert property (s_pin_load |=>
		cfg_ff.decim[1] == $past(pin_ff.decim_select_hi) &&
		cfg_ff.decim[0] == $past(pin_ff.decim_select_lo))
		else $error("decimation select wrong");
	a_mode_code14: assert property (s_pin_load and
		(pin_ff.mode_strap_pins == 4'he) |=> cfg_ff.pwr == PWR_FAST &&
		cfg_ff.data_clock == DATA_CLOCK_DIV2 && cfg_ff.one_shot)
		else $error("mode code 14 decoded wrong");
	a_mod_rate: assert property (valid_ff && !serial_ff |->
		cfg_ff.mdiv == mod_div(cfg_ff.pwr))
		else $error("modulator divider wrong for power mode");
	a_fmt_follow: assert property (##1 output_format_select_o ==
		$past(pin_ff.output_format_select))
		else $error("format select not following pins");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

endmodule : acd_strap_decoder

//--- testbench/acd_host_model.sv
module acd_host_model (
	// Clock.
	input wire logic clk_i,
	// Strap pins toward the block.
	output acd_pkg::acd_pins_s pins_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import acd_pkg::*;

	initial begin
		pins_o = '0;
		pins_o.start_n = 1'b1;
		pins_o.sync_in_n = 1'b1;
	end

	// Bits 11:3 are filter, decimation hi/lo, mode and format pins.
	task automatic set_straps(input logic ser, input logic [8:0] v);
		@(posedge clk_i);
		pins_o.ctrl_serial <= ser;
		pins_o[11:3] <= v;
	endtask : set_straps

	// Low for four clocks so the synchroniser cannot miss it.
	task automatic pulse_sync(input logic use_start);
		@(posedge clk_i);
		if (use_start) begin
			pins_o.start_n <= 1'b0;
		end else begin
			pins_o.sync_in_n <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		pins_o.start_n <= 1'b1;
		pins_o.sync_in_n <= 1'b1;
		repeat (10) @(posedge clk_i);
	endtask : pulse_sync

	task automatic fault_pulse();
		@(posedge clk_i);
		pins_o.supply_fault <= 1'b1;
		repeat (4) @(posedge clk_i);
		pins_o.supply_fault <= 1'b0;
		repeat (10) @(posedge clk_i);
	endtask : fault_pulse
endmodule : acd_host_model

//--- testbench/adc_pin_strap_config_decoder_tb_top.sv
`define CHK(what, e, g) begin samples_checked++; if ((g) !== (e)) begin \
fails++; $display("Error %s expected %h seen %h", what, e, g); end end

module adc_pin_strap_config_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import acd_pkg::*;

	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	acd_pins_s pins;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	acd_cfg_s cfg_o;
	logic cfg_valid_o;
	logic serial_mode_o;
	logic [1:0] fmt_o;
	logic shared_o;
	int fails = 0;
	int samples_checked = 0;
	int cyc_cnt = 0;
	logic [31:0] exp_q[$];
	logic [31:0] e;
	logic [8:0] v;
	logic [8:0] old;
	logic [9:0] c;
	logic [15:0] p;

	acd_strap_decoder DUT (
		.clk_i(clk_i), .rst_i(rst_i), .strap_pins_i(pins),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cfg_o(cfg_o),
		.cfg_valid_o(cfg_valid_o), .serial_mode_o(serial_mode_o),
		.output_format_select_o(fmt_o), .shared_data_out_o(shared_o)
	);

	acd_host_model PART (
		.clk_i(clk_i),
		.pins_o(pins)
	);

	always #25 clk_i = ~clk_i;

	// ************************************************************
	// Expected configurations.
	// ************************************************************
	function automatic logic [31:0] pin_cfg(input logic [8:0] s);
		acd_cfg_s k;
		k.sinc5 = s[8];
		k.decim = acd_dec_e'(s[7:6]);
		k.one_shot = s[5] & s[4];
		k.pwr = acd_pwr_e'(s[5:4]);
		k.data_clock = acd_data_clock_e'(s[3:2]);
		if (k.one_shot) begin
			k.pwr = s[3] ? PWR_FAST : s[2] ? PWR_MEDIAN : PWR_FOCUS;
			k.data_clock = s[3:2] == 2'h2 ? DATA_CLOCK_DIV2 : DATA_CLOCK_DIV1;
		end
		k.mdiv = k.pwr == PWR_FAST ? MDIV_4 :
			k.pwr == PWR_MEDIAN ? MDIV_8 : MDIV_32;
		k.ain_buf = 8'hff;
		k.ref_buf = 8'h00;
		return {6'h00, k};
	endfunction : pin_cfg

	function automatic logic [31:0] ser_cfg(logic [9:0] r, logic [15:0] q);
		return {6'h00, r[0], r[2:1], r[4:3], r[6:5], r[7], r[9:8], q[7:0],
			q[15:8]};
	endfunction : ser_cfg

	// ************************************************************
	// Bus master and result monitor.
	// ************************************************************
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		exp_q.push_back(x);
		wb(1'b0, a, 32'h0);
	endtask : rd

	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
			e = exp_q.pop_front();
			`CHK("read data", e, wb_dat_o)
			if (wb_adr_i === ADR_ACTIVE) begin
				`CHK("cfg_o", e[25:0], cfg_o)
			end
			if (wb_adr_i === ADR_STATUS) begin
				`CHK("serial_mode_o", e[0], serial_mode_o)
				`CHK("cfg_valid_o", e[1], cfg_valid_o)
				`CHK("fmt_o", e[3:2], fmt_o)
				`CHK("shared_o", |e[3:2], shared_o)
			end
		end
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			fails++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	task automatic hard_reset(input logic ser);
		PART.set_straps(ser, v);
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask : hard_reset

	initial begin
		void'($urandom(32'h9b6a));
		v = 9'($urandom);
		hard_reset(1'b0);
		rd(ADR_ACTIVE, pin_cfg(v));
		rd(ADR_STATUS, {26'h0, 2'b10, v[1:0], 2'b10});
		$display("test power_up done");
		for (int m = 0; m < 16; m++) begin
			old = v;
			v = 9'($urandom);
			v[5:2] = 4'(m);
			PART.set_straps(1'b0, v);
			repeat (6) @(posedge clk_i);
			rd(ADR_ACTIVE, pin_cfg(old));
			PART.pulse_sync(m[0]);
			rd(ADR_ACTIVE, pin_cfg(v));
			rd(ADR_STATUS, {26'h0, 2'b10, v[1:0], 2'b10});
		end
		$display("test mode_codes done");
		v = 9'($urandom);
		PART.set_straps(1'b0, v);
		PART.fault_pulse();
		rd(ADR_ACTIVE, pin_cfg(v));
		wb(1'b1, ADR_CTRL, 32'hffff_ffff);
		rd(ADR_CTRL, 32'h0000_03ff);
		wb(1'b1, ADR_STATUS, 32'hffff_ffff);
		rd(ADR_STATUS, {26'h0, 2'b10, v[1:0], 2'b10});
		rd(8'h14, 32'h0);
		PART.pulse_sync(1'b1);
		rd(ADR_ACTIVE, pin_cfg(v));
		wb(1'b1, ADR_SOFTRST, {24'h0, SOFTRST_KEY});
		rd(ADR_CTRL, CTRL_RST);
		rd(ADR_PRECHG, PRECHG_RST);
		rd(ADR_ACTIVE, pin_cfg(v));
		$display("test fault_and_regs done");
		hard_reset(1'b1);
		rd(ADR_STATUS, {26'h0, 2'b10, v[1:0], 2'b11});
		rd(ADR_ACTIVE, ser_cfg(CTRL_RST[9:0], PRECHG_RST[15:0]));
		c = 10'($urandom);
		c[4:3] = 2'h2;
		c[9:8] = 2'h0;
		p = 16'($urandom);
		wb(1'b1, ADR_CTRL, {22'h0, c});
		wb(1'b1, ADR_PRECHG, {16'h0, p});
		v = 9'($urandom);
		PART.set_straps(1'b1, v);
		PART.pulse_sync(1'b0);
		rd(ADR_ACTIVE, ser_cfg(c, p));
		wb(1'b1, ADR_SOFTRST, {24'h0, SOFTRST_KEY});
		rd(ADR_ACTIVE, ser_cfg(CTRL_RST[9:0], PRECHG_RST[15:0]));
		$display("test serial_mode done");
		report_and_stop();
	end
endmodule : adc_pin_strap_config_decoder_tb_top
